/* File: verilog/debug_conduit_pkg.sv */
// shared constants and carrier types for the debug status and control conduit
package debug_conduit_pkg;

	// ****************************************
	// bus widths
	// ****************************************
	localparam int STATUS_W = 256;
	localparam int CTRL_W = 256;
	localparam int TEST_IN_W = 32;

	// ****************************************
	// status bus field positions
	// ****************************************
	localparam int POS_SPEED = 0;
	localparam int POS_RCV_COR = 2;
	localparam int POS_RPL_COR = 3;
	localparam int POS_UNCOR = 4;
	localparam int POS_RX_PAR = 5;
	localparam int POS_TX_PAR = 6;
	localparam int POS_CFG_PAR = 8;
	localparam int POS_LINK_UP = 9;
	localparam int POS_LINK_UP_EXIT = 10;
	localparam int POS_TICK_SHORT = 11;
	localparam int POS_TICK_LONG = 12;
	localparam int POS_HOT_RST_EXIT = 13;
	localparam int POS_INT_STATUS = 14;
	localparam int POS_LOW_PWR_EXIT = 18;
	localparam int POS_LANES = 19;
	localparam int POS_TRAIN_STATE = 23;
	localparam int POS_CPL_HDR = 28;
	localparam int POS_CPL_DATA = 36;
	localparam int POS_CPL_OVF = 48;
	localparam int POS_CORE_RST = 49;
	localparam int USED_W = 50;

	// ****************************************
	// link training state codes
	// ****************************************
	localparam logic [4:0] TRAIN_DETECT_QUIET = 5'h00;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int ADR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_TEST_OVR = 8'h04;
	localparam logic [7:0] OFF_STATUS_LO = 8'h08;
	localparam logic [7:0] OFF_STATUS_HI = 8'h0c;
	localparam logic [7:0] OFF_BOARD_CTRL = 8'h10;
	localparam logic [7:0] OFF_ERR_STICKY = 8'h14;
	localparam logic [7:0] OFF_LINK_INFO = 8'h18;

	// control register fields
	localparam int CTRL_OVERRIDE = 0;
	localparam int CTRL_FREEZE = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// typical test input setting: bit0=0, 4:1=0100, 6:5=01, 31:7=3
	localparam logic [31:0] TEST_IN_TYPICAL = 32'h000001a8;
	localparam logic [7:0] ERR_STICKY_RESET = 8'h00;
	localparam int ERR_W = 8;

	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic core_reset;
		logic cpl_buf_overflow;
		logic [11:0] completion_data_credits;
		logic [7:0] completion_header_credits;
		logic [4:0] train_state;
		logic [3:0] lanes_active;
		logic low_power_exit;
		logic [3:0] int_status;
		logic hot_reset_exit;
		logic tick_long_period;
		logic tick_short_period;
		logic link_up_exit;
		logic link_up;
		logic cfg_par_err;
		logic [1:0] tx_par_err;
		logic rx_par_err;
		logic uncor_err;
		logic rpl_cor_err;
		logic rcv_cor_err;
		logic [1:0] current_speed;
	} core_status_s;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} wb_req_s;

	typedef enum logic [0:0] {
		WB_IDLE = 1'b0,
		WB_ACK = 1'b1
	} wb_state_e;

endpackage : debug_conduit_pkg

/* File: verilog/status_packer.sv */
// places the core indications at their fixed positions on the status bus
`timescale 1ns/1ps
module status_packer
(
	input wire debug_conduit_pkg::core_status_s core_in,
	output logic [255:0] status_out
);

	always_comb
	begin
		status_out = '0;
		status_out[debug_conduit_pkg::POS_SPEED +: 2] = core_in.current_speed;
		status_out[debug_conduit_pkg::POS_RCV_COR] = core_in.rcv_cor_err;
		status_out[debug_conduit_pkg::POS_RPL_COR] = core_in.rpl_cor_err;
		status_out[debug_conduit_pkg::POS_UNCOR] = core_in.uncor_err;
		status_out[debug_conduit_pkg::POS_RX_PAR] = core_in.rx_par_err;
		status_out[debug_conduit_pkg::POS_TX_PAR +: 2] = core_in.tx_par_err;
		status_out[debug_conduit_pkg::POS_CFG_PAR] = core_in.cfg_par_err;
		status_out[debug_conduit_pkg::POS_LINK_UP] = core_in.link_up;
		status_out[debug_conduit_pkg::POS_LINK_UP_EXIT] = core_in.link_up_exit;
		status_out[debug_conduit_pkg::POS_TICK_SHORT] = core_in.tick_short_period;
		status_out[debug_conduit_pkg::POS_TICK_LONG] = core_in.tick_long_period;
		status_out[debug_conduit_pkg::POS_HOT_RST_EXIT] = core_in.hot_reset_exit;
		// the interrupt field sits in the only free gap below the exit bit
		status_out[debug_conduit_pkg::POS_INT_STATUS +: 4] = core_in.int_status;
		status_out[debug_conduit_pkg::POS_LOW_PWR_EXIT] = core_in.low_power_exit;
		status_out[debug_conduit_pkg::POS_LANES +: 4] = core_in.lanes_active;
		status_out[debug_conduit_pkg::POS_TRAIN_STATE +: 5] = core_in.train_state;
		status_out[debug_conduit_pkg::POS_CPL_HDR +: 8] = core_in.completion_header_credits;
		status_out[debug_conduit_pkg::POS_CPL_DATA +: 12] = core_in.completion_data_credits;
		status_out[debug_conduit_pkg::POS_CPL_OVF] = core_in.cpl_buf_overflow;
		status_out[debug_conduit_pkg::POS_CORE_RST] = core_in.core_reset;
	end

endmodule : status_packer

/* File: verilog/test_in_select.sv */
// registered choice of the core test inputs: board switches or software value
`timescale 1ns/1ps
module test_in_select
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic override_in,
	input wire logic [31:0] board_in,
	input wire logic [31:0] soft_in,
	output logic [31:0] test_in_out
);

	logic [31:0] test_in;
	logic [31:0] next_test_in;

	always_comb
	begin
		if (override_in)
		begin
			next_test_in = soft_in;
		end
		else
		begin
			next_test_in = board_in;
		end
	end

	// reset lands on the typical setting so the core starts in normal mode
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			test_in <= debug_conduit_pkg::TEST_IN_TYPICAL;
		end
		else
		begin
			test_in <= next_test_in;
		end
	end

	assign test_in_out = test_in;

endmodule : test_in_select

/* File: verilog/debug_status_control_conduit.sv */
// debug status and control conduit between the link core and a board
//
// What this block does
// - link speed on status bits 1:0
// - data error flags on bits 2, 3, 4
// - parity errors on bits 5, 7:6, 8
// - link up on 9, exit on 10
// - short then long tick on 11, 12
// - hot reset exit on bit 13
// - interrupt status field carried on status bus
// - low power exit 18, lanes 22:19
// - training state 27:23, header credits 35:28
// - data credits 47:36, overflow on 48
// - core reset on 49, 255:50 reserved
// - 256-bit status out, 256-bit control in
// - conduit exists only when option enabled
// - training state zero means quiet detect
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module debug_status_control_conduit
#(
	parameter bit CONDUIT_ENABLE = 1'b1
)
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire debug_conduit_pkg::core_status_s core_status_in,
	input wire logic [255:0] board_ctrl_in,
	output logic [255:0] debug_status_out,
	output logic [31:0] test_in_out,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0] sel
	);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	function automatic logic [7:0] error_bits(
		input debug_conduit_pkg::core_status_s s
	);
		return {s.cpl_buf_overflow, s.cfg_par_err, s.tx_par_err, s.rx_par_err,
			s.uncor_err, s.rpl_cor_err, s.rcv_cor_err};
	endfunction : error_bits

	// ****************************************
	// request bundle
	// ****************************************
	debug_conduit_pkg::wb_req_s req;

	always_comb
	begin
		req.cyc = wb_cyc_in;
		req.stb = wb_stb_in;
		req.we = wb_we_in;
		req.sel = wb_sel_in;
		req.adr = wb_adr_in;
		req.dat = wb_dat_in;
	end

	logic [255:0] packed_status;
	logic [31:0] selected_test_in;

	status_packer u_packer
	(
		.core_in(core_status_in),
		.status_out(packed_status)
	);

	// ****************************************
	// software control state
	// ****************************************
	logic [1:0] ctrl;
	logic [1:0] next_ctrl;
	logic [31:0] test_ovr;
	logic [31:0] next_test_ovr;
	logic [7:0] err_sticky;
	logic [7:0] next_err_sticky;

	// ****************************************
	// bus handshake state
	// ****************************************
	debug_conduit_pkg::wb_state_e wb_state;
	debug_conduit_pkg::wb_state_e next_wb_state;
	logic [31:0] rd_data;
	logic [31:0] next_rd_data;

	// ****************************************
	// status output state
	// ****************************************
	logic [255:0] status;
	logic [255:0] next_status;

	logic access;
	logic wr_fire;
	logic [7:0] err_now;

	// a request is taken only from idle so ack is a single-cycle pulse
	assign access = req.cyc && req.stb && (wb_state == debug_conduit_pkg::WB_IDLE);
	// a write lands at the edge where the master sees ack, while it still holds the request
	assign wr_fire = req.cyc && req.stb && req.we && (wb_state == debug_conduit_pkg::WB_ACK);
	assign err_now = error_bits(core_status_in);

	generate
		if (CONDUIT_ENABLE)
		begin : g_conduit
			test_in_select u_sel
			(
				.clk_in(clk_in),
				.rst_in(rst_in),
				.override_in(ctrl[debug_conduit_pkg::CTRL_OVERRIDE]),
				// upper control bits have no consumer; the board keeps them zero
				.board_in(board_ctrl_in[31:0]),
				.soft_in(test_ovr),
				.test_in_out(selected_test_in)
			);
		end
		else
		begin : g_absent
			// without the option the core sees its typical test setting
			assign selected_test_in = debug_conduit_pkg::TEST_IN_TYPICAL;
		end
	endgenerate

	// ****************************************
	// next-state logic for control registers
	// ****************************************
	always_comb
	begin
		next_ctrl = ctrl;
		next_test_ovr = test_ovr;
		next_err_sticky = err_sticky;
		if (wr_fire)
		begin
			case (req.adr)
				debug_conduit_pkg::OFF_CTRL:
				begin
					if (req.sel[0])
					begin
						next_ctrl = req.dat[1:0];
					end
				end
				debug_conduit_pkg::OFF_TEST_OVR:
				begin
					next_test_ovr = merge_bytes(test_ovr, req.dat, req.sel);
				end
				debug_conduit_pkg::OFF_ERR_STICKY:
				begin
					if (req.sel[0])
					begin
						next_err_sticky = err_sticky & ~req.dat[7:0];
					end
				end
				default:
				begin
					next_ctrl = ctrl;
				end
			endcase
		end
		// a new error in the clearing cycle survives the clear
		next_err_sticky = next_err_sticky | err_now;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ctrl <= debug_conduit_pkg::CTRL_RESET;
			test_ovr <= debug_conduit_pkg::TEST_IN_TYPICAL;
			err_sticky <= debug_conduit_pkg::ERR_STICKY_RESET;
		end
		else
		begin
			ctrl <= next_ctrl;
			test_ovr <= next_test_ovr;
			err_sticky <= next_err_sticky;
		end
	end

	// ****************************************
	// bus answer: one cycle after the request is seen
	// ****************************************
	always_comb
	begin
		next_wb_state = wb_state;
		next_rd_data = rd_data;
		case (wb_state)
			debug_conduit_pkg::WB_IDLE:
			begin
				if (access)
				begin
					next_wb_state = debug_conduit_pkg::WB_ACK;
					case (req.adr)
						debug_conduit_pkg::OFF_CTRL:
						begin
							next_rd_data = {30'h0, ctrl};
						end
						debug_conduit_pkg::OFF_TEST_OVR:
						begin
							next_rd_data = test_ovr;
						end
						debug_conduit_pkg::OFF_STATUS_LO:
						begin
							next_rd_data = status[31:0];
						end
						debug_conduit_pkg::OFF_STATUS_HI:
						begin
							next_rd_data = status[63:32];
						end
						debug_conduit_pkg::OFF_BOARD_CTRL:
						begin
							next_rd_data = selected_test_in;
						end
						debug_conduit_pkg::OFF_ERR_STICKY:
						begin
							next_rd_data = {24'h000000, err_sticky};
						end
						debug_conduit_pkg::OFF_LINK_INFO:
						begin
							next_rd_data = {26'h0,
								core_status_in.train_state ==
								debug_conduit_pkg::TRAIN_DETECT_QUIET,
								core_status_in.link_up,
								core_status_in.lanes_active};
						end
						default:
						begin
							// unmapped reads answer with zero, writes are dropped
							next_rd_data = 32'h00000000;
						end
					endcase
				end
			end
			debug_conduit_pkg::WB_ACK:
			begin
				next_wb_state = debug_conduit_pkg::WB_IDLE;
			end
			default:
			begin
				next_wb_state = debug_conduit_pkg::WB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wb_state <= debug_conduit_pkg::WB_IDLE;
			rd_data <= 32'h00000000;
		end
		else
		begin
			wb_state <= next_wb_state;
			rd_data <= next_rd_data;
		end
	end

	// ****************************************
	// status bus register
	// ****************************************
	// freeze lets a slow monitor read a coherent picture; strobes may be missed
	always_comb
	begin
		if (!CONDUIT_ENABLE)
		begin
			next_status = '0;
		end
		else if (ctrl[debug_conduit_pkg::CTRL_FREEZE])
		begin
			next_status = status;
		end
		else
		begin
			next_status = packed_status;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			status <= '0;
		end
		else
		begin
			status <= next_status;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign debug_status_out = status;
	assign test_in_out = selected_test_in;
	assign wb_dat_out = rd_data;
	assign wb_ack_out = (wb_state == debug_conduit_pkg::WB_ACK);

endmodule : debug_status_control_conduit

/* File: verif/debug_conduit_chk.sv */
// assertion checker for the debug status and control conduit
`timescale 1ns/1ps
module debug_conduit_chk
#(
	parameter bit CONDUIT_ENABLE = 1'b1
)
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire debug_conduit_pkg::core_status_s core_status_in,
	input wire logic [255:0] board_ctrl_in,
	input wire logic [255:0] debug_status_out,
	input wire logic [31:0] test_in_out,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out
);
	// ****
	// shadow of the control register
	// ****
	// freeze and override mask the pass-through checks, so track them from bus writes
	logic frz;
	logic ovr;
	logic next_frz;
	logic next_ovr;
	logic take;
	assign take = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_sel_in[0]
		&& wb_adr_in == debug_conduit_pkg::OFF_CTRL;
	always_comb
	begin
		next_frz = take ? wb_dat_in[debug_conduit_pkg::CTRL_FREEZE] : frz;
		next_ovr = take ? wb_dat_in[debug_conduit_pkg::CTRL_OVERRIDE] : ovr;
	end
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			frz <= 1'b0;
			ovr <= 1'b0;
		end
		else
		begin
			frz <= next_frz;
			ovr <= next_ovr;
		end
	end
	// the first edge after a release still shows reset values, so it is skipped too
	logic rst_hold;
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rst_hold <= 1'b1;
		end
		else
		begin
			rst_hold <= 1'b0;
		end
	end
	// ****
	// properties
	// ****
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in || rst_hold || !CONDUIT_ENABLE);
	sequence s_req;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	sequence s_ack;
		wb_ack_out ##1 !wb_ack_out;
	endsequence
	property p_errs;
		!frz |=> debug_status_out[8:0] == $past(core_status_in[8:0]);
	endproperty
	property p_link;
		!frz |=> debug_status_out[13:9] == $past(core_status_in[13:9]);
	endproperty
	property p_int;
		!frz |=> debug_status_out[17:14] == $past(core_status_in.int_status);
	endproperty
	property p_lanes;
		!frz |=> debug_status_out[35:18] == $past(core_status_in[35:18]);
	endproperty
	property p_credits;
		!frz |=> debug_status_out[49:36] == $past(core_status_in[49:36]);
	endproperty
	property p_resv;
		debug_status_out[255:50] == 206'h0;
	endproperty
	property p_test;
		!ovr |=> test_in_out == $past(board_ctrl_in[31:0]);
	endproperty
	property p_ack;
		s_req |=> s_ack;
	endproperty
	a_errs: assert property (p_errs) else $error("status bits 8:0 wrong");
	a_link: assert property (p_link) else $error("status bits 13:9 wrong");
	a_int: assert property (p_int) else $error("interrupt status wrong");
	a_lanes: assert property (p_lanes) else $error("status bits 35:18 wrong");
	a_credits: assert property (p_credits) else $error("status bits 49:36 wrong");
	a_resv: assert property (p_resv) else $error("reserved status not zero");
	a_test: assert property (p_test) else $error("test inputs not passed");
	a_ack: assert property (p_ack) else $error("bus answer not a one cycle pulse");
endmodule : debug_conduit_chk

bind debug_status_control_conduit debug_conduit_chk #(.CONDUIT_ENABLE(CONDUIT_ENABLE)) u_chk
(
	.clk_in(clk_in), .rst_in(rst_in), .core_status_in(core_status_in),
	.board_ctrl_in(board_ctrl_in), .debug_status_out(debug_status_out),
	.test_in_out(test_in_out), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
	.wb_we_in(wb_we_in), .wb_sel_in(wb_sel_in), .wb_adr_in(wb_adr_in),
	.wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out)
);

/* File: verif/board_model.sv */
// board model: switch bank feeding the conduit control bus
`timescale 1ns/1ps
module board_model
(
	input wire logic bypass_in,
	output wire logic [255:0] board_ctrl_out
);
	// ****
	// switch bank
	// ****
	// static levels; the one switch models a hand-set compliance bypass
	assign board_ctrl_out = {224'h0, 25'h3, 2'b01, 4'b0100, bypass_in};
endmodule : board_model

/* File: verif/testbench.sv */
// self-checking bench for the debug status and control conduit
`timescale 1ns/1ps
module testbench;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	debug_conduit_pkg::core_status_s core_status_in = '0;
	debug_conduit_pkg::core_status_s v;
	logic bypass = 1'b0;
	logic [255:0] board_ctrl_in;
	logic [255:0] debug_status_out;
	logic [255:0] status_off;
	logic [31:0] test_in_out;
	logic [31:0] test_off;
	logic wb_cyc_in = 1'b0;
	logic wb_stb_in = 1'b0;
	logic wb_we_in = 1'b0;
	logic [3:0] wb_sel_in = 4'h0;
	logic [7:0] wb_adr_in = 8'h00;
	logic [31:0] wb_dat_in = 32'h0;
	logic [31:0] wb_dat_out;
	logic wb_ack_out;
	logic [31:0] rd;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;

	always #12.5 clk_in = ~clk_in;

	board_model u_board (.bypass_in(bypass), .board_ctrl_out(board_ctrl_in));
	debug_status_control_conduit DUT (.clk_in(clk_in), .rst_in(rst_in),
		.core_status_in(core_status_in), .board_ctrl_in(board_ctrl_in),
		.debug_status_out(debug_status_out), .test_in_out(test_in_out),
		.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
		.wb_sel_in(wb_sel_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in),
		.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));
	debug_status_control_conduit #(.CONDUIT_ENABLE(1'b0)) u_off (.clk_in(clk_in),
		.rst_in(rst_in), .core_status_in(core_status_in), .board_ctrl_in(board_ctrl_in),
		.debug_status_out(status_off), .test_in_out(test_off),
		.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
		.wb_sel_in(wb_sel_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in),
		.wb_dat_out(), .wb_ack_out());

	// ****
	// tasks
	// ****
	task finish_test;
	begin
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask : finish_test

	task check(input string what, input logic [255:0] exp, input logic [255:0] got);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	end
	endtask : check

	// entered and left at a rising edge; ack and read data are taken at the same edge
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
	begin
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_sel_in <= 4'hf;
		wb_adr_in <= a;
		wb_dat_in <= d;
		@(posedge clk_in);
		while (wb_ack_out !== 1'b1)
			@(posedge clk_in);
		rd = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in <= 1'b0;
		@(posedge clk_in);
	end
	endtask : wb

	task step(input debug_conduit_pkg::core_status_s s);
	begin
		core_status_in <= s;
		@(posedge clk_in);
		@(posedge clk_in);
	end
	endtask : step

	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			failures++;
			$display("timeout");
			finish_test();
		end
	end

	// ****
	// tests
	// ****
	initial
	begin
		repeat (6) @(posedge clk_in);
		check("reset status", 256'h0, debug_status_out);
		check("reset test in", 256'h1a8, test_in_out);
		rst_in <= 1'b0;
		@(posedge clk_in);
		$display("test reset done");
		for (int i = 0; i < 50; i++)
		begin
			step(debug_conduit_pkg::core_status_s'(50'h1 << i));
			check("status walk", 256'h1 << i, debug_status_out);
		end
		$display("test walking bit done");
		v = '0;
		v.current_speed = 2'h2;
		v.int_status = 4'ha;
		v.lanes_active = 4'h5;
		v.completion_header_credits = 8'hc3;
		v.completion_data_credits = 12'h9a5;
		v.tick_short_period = 1'b1;
		step(v);
		check("speed", 256'h2, debug_status_out[1:0]);
		check("short tick", 256'h1, debug_status_out[11]);
		check("int status", 256'ha, debug_status_out[17:14]);
		check("lanes", 256'h5, debug_status_out[22:19]);
		check("hdr credits", 256'hc3, debug_status_out[35:28]);
		check("data credits", 256'h9a5, debug_status_out[47:36]);
		check("disabled status", 256'h0, status_off);
		check("disabled test in", 256'h1a8, test_off);
		wb(1'b0, 8'h18, 32'h0);
		check("link info", 256'h25, rd);
		wb(1'b0, 8'h08, 32'h0);
		check("status lo", 256'h302a8802, rd);
		wb(1'b0, 8'h0c, 32'h0);
		check("status hi", 256'h9a5c, rd);
		wb(1'b0, 8'h40, 32'h0);
		check("unmapped", 256'h0, rd);
		$display("test fields done");
		check("test in", 256'h1a8, test_in_out);
		bypass <= 1'b1;
		step(v);
		check("bypass", 256'h1a9, test_in_out);
		wb(1'b0, 8'h10, 32'h0);
		check("board ctrl", 256'h1a9, rd);
		wb(1'b1, 8'h04, 32'h5a5a0f0f);
		wb(1'b1, 8'h00, 32'h1);
		step(v);
		check("override", 256'h5a5a0f0f, test_in_out);
		check("disabled override", 256'h1a8, test_off);
		wb(1'b1, 8'h00, 32'h0);
		step(v);
		check("override off", 256'h1a9, test_in_out);
		$display("test control done");
		wb(1'b1, 8'h00, 32'h2);
		v.current_speed = 2'h1;
		step(v);
		check("frozen", 256'h2, debug_status_out[1:0]);
		wb(1'b1, 8'h00, 32'h0);
		step(v);
		check("unfrozen", 256'h1, debug_status_out[1:0]);
		wb(1'b1, 8'h14, 32'hff);
		v.rcv_cor_err = 1'b1;
		step(v);
		v.rcv_cor_err = 1'b0;
		step(v);
		wb(1'b0, 8'h14, 32'h0);
		check("sticky", 256'h1, rd);
		wb(1'b1, 8'h14, 32'h1);
		wb(1'b0, 8'h14, 32'h0);
		check("sticky clear", 256'h0, rd);
		rst_in <= 1'b1;
		@(posedge clk_in);
		@(posedge clk_in);
		check("second reset", 256'h0, debug_status_out);
		rst_in <= 1'b0;
		step(v);
		check("after reset", 256'h1, debug_status_out[1:0]);
		$display("test registers done");
		finish_test();
	end
endmodule : testbench
